// File: hdl/pdmc_top.sv
/*
  pdm input front end: bit capture, channel pick, pattern control,
  strap default, standby and clock-loss power-down, supply reset.
  assumes all pins but clk, rst and the register port are asynchronous to clk and the bit clock is far
  slower than clk; the strap pad sensing delivers level and resistor.
*/
// Chosen here: the register offsets and the strobed register port.
// Operation
// - runs only while the bit clock toggles; data is synchronous to it
// - strap latched when supplies first come good, used as default
// - smart power-down enters standby after 129 repeated stop bytes
// - clock removed in standby means full power-down
// - clock back plus one non-stop input resumes with strap defaults
// - internal reset while either supply is bad; output stopped
// - strap decodes to rate 64x/128x and gain 5 V/3.6 V
// - patterns override the strap configuration during operation
// - rate picks one of two decimation filters
// - gain scale gives 5 V, 3.6 V or 2.5 V peak at -6.02 dBFS
// - channel select low routes left, high routes right
// - pattern acts after 129 repeats; output muted while seen
// - decode gain patterns and the opposite-rate pattern
// - clock-loss power-down restores every pattern setting
`timescale 1ns/1ps
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter int REPEAT   = `PDMC_PAT_REPEAT,
  parameter int LOSS_CYC = `PDMC_LOSS_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pdm_clk_in,
  input  wire logic        pdm_bitstream_in,
  input  wire logic        channel_side_select,
  input  wire pdmc_strap_t gain_rate_strap,
  input  wire logic        power_stage_supply_good,
  input  wire logic        logic_supply_good,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata_q,
  output logic             audio_bit_q,
  output logic             audio_valid_q,
  output logic             out_enable_q,
  output logic             mute_q,
  output pdmc_cfg_t        cfg_q,
  output logic             decim_128x_q,
  output logic      [7:0]  gain_scale_q,
  output pdmc_state_t      state_q
);

  localparam int RUN_BITS = (REPEAT - 1) * 8;
  localparam int RW       = $clog2(RUN_BITS + 1);
  localparam int LW       = $clog2(LOSS_CYC + 1);

  initial begin
    if (REPEAT < 2 || LOSS_CYC < 4) begin
      $error("pdmc_top: unsupported REPEAT or LOSS_CYC");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every input except clk, rst and the register port passes two flops first
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic       clk_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q       <= 7'h00;
      s2_q       <= 7'h00;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q       <= {pdm_clk_in, pdm_bitstream_in, channel_side_select,
                     gain_rate_strap, power_stage_supply_good,
                     logic_supply_good};
      s2_q       <= s1_q;
      clk_prev_q <= s2_q[6];
    end
  end

  // named views of the synchronised pins
  wire         pclk_s  = s2_q[6];
  wire         data_s  = s2_q[5];
  wire         right_s = s2_q[4];
  pdmc_strap_t strap_s;
  assign strap_s = pdmc_strap_t'(s2_q[3:2]);
  wire core_rst  = rst | ~s2_q[1] | ~s2_q[0];
  wire rise      = pclk_s & ~clk_prev_q;
  wire fall      = ~pclk_s & clk_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // channel capture: left on rising, right on falling edge
  wire take_bit = right_s ? fall : rise;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      audio_bit_q   <= 1'b0;
      audio_valid_q <= 1'b0;
    end else begin
      audio_valid_q <= take_bit;
      if (take_bit) begin
        audio_bit_q <= data_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit clock loss watchdog
  logic [LW-1:0] loss_cnt_q;
  wire           clk_edge = rise | fall;
  wire           clk_lost = (loss_cnt_q == LW'(LOSS_CYC));

  always_ff @(posedge clk) begin
    if (core_rst || clk_edge) begin
      loss_cnt_q <= '0;
    end else if (!clk_lost) begin
      loss_cnt_q <= loss_cnt_q + LW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern watch: window, fill count and period-8 run length
  logic [7:0]    win_q;
  logic [3:0]    fill_q;
  logic [RW-1:0] run_q;
  logic          acted_q;

  wire [7:0] win_d    = {win_q[6:0], data_s};
  wire       full     = fill_q[3];
  wire       periodic = full & (data_s == win_q[7]);
  wire       run_max  = (run_q == RW'(RUN_BITS));
  wire       got_pat  = take_bit & periodic &
                        (run_q == RW'(RUN_BITS - 1)) & ~acted_q;
  wire       is_stop  = (win_d == `PDMC_PAT_STOP);
  wire       break_in = take_bit & full & ~periodic;
  wire       wipe     = clk_lost & (state_q != PDMC_POWERDOWN);

  always_ff @(posedge clk) begin
    if (core_rst || wipe) begin
      win_q   <= 8'h00;
      fill_q  <= 4'h0;
      run_q   <= '0;
      acted_q <= 1'b0;
    end else if (take_bit) begin
      win_q   <= win_d;
      fill_q  <= full ? fill_q : fill_q + 4'h1;
      run_q   <= !periodic ? '0 : (run_max ? run_q : run_q + RW'(1));
      acted_q <= periodic & (acted_q | got_pat);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture at the first cycle with both supplies good
  logic        strap_done_q;
  pdmc_strap_t strap_q;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      strap_done_q <= 1'b0;
      strap_q      <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= strap_s;
    end
  end

  // default configuration from the strap
  pdmc_strap_t strap_use;
  pdmc_cfg_t   cfg_def;
  assign strap_use         = strap_done_q ? strap_q : strap_s;
  assign cfg_def.rate_128x = strap_use.level_high;
  assign cfg_def.gain      = strap_use.via_resistor ? PDMC_GAIN_50
                                                    : PDMC_GAIN_36;

  ////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ctrl_q;
  wire        spd_en = ctrl_q[`PDMC_CTRL_SPD];

  always_ff @(posedge clk) begin
    if (core_rst) begin
      ctrl_q <= `PDMC_CTRL_RST;
    end else if (reg_wr && reg_addr == `PDMC_REG_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  pdmc_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PDMC_RUN: begin
        if (clk_lost) begin
          state_d = PDMC_POWERDOWN;
        end else if (got_pat && is_stop && spd_en) begin
          state_d = PDMC_STANDBY;
        end
      end
      PDMC_STANDBY: begin
        if (clk_lost) begin
          state_d = PDMC_POWERDOWN;
        end else if (break_in) begin
          state_d = PDMC_RUN;
        end
      end
      PDMC_POWERDOWN: begin
        if (break_in) begin
          state_d = PDMC_RUN;
        end
      end
      default: begin
        state_d = PDMC_POWERDOWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_q <= PDMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern-controlled configuration and mute
  wire act = got_pat & (state_q == PDMC_RUN);
  logic mute_pat_q;

  always_ff @(posedge clk) begin
    if (core_rst || !strap_done_q || wipe) begin
      cfg_q      <= cfg_def;
      mute_pat_q <= 1'b0;
    end else if (act) begin
      case (win_d)
        `PDMC_PAT_G36:   cfg_q.gain      <= PDMC_GAIN_36;
        `PDMC_PAT_G25:   cfg_q.gain      <= PDMC_GAIN_25;
        `PDMC_PAT_G50:   cfg_q.gain      <= PDMC_GAIN_50;
        `PDMC_PAT_RATE:  cfg_q.rate_128x <= ~cfg_def.rate_128x;
        `PDMC_PAT_MUTE:  mute_pat_q      <= 1'b1;
        `PDMC_PAT_RESET: begin
          cfg_q      <= cfg_def;
          mute_pat_q <= 1'b0;
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // gain scale and filter pick follow the configuration
  wire [7:0] scale_d = (cfg_q.gain == PDMC_GAIN_50) ? `PDMC_SCALE_G50 :
                       (cfg_q.gain == PDMC_GAIN_36) ? `PDMC_SCALE_G36 :
                                                      `PDMC_SCALE_G25;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      gain_scale_q <= `PDMC_SCALE_G36;
      decim_128x_q <= 1'b0;
      mute_q       <= 1'b1;
      out_enable_q <= 1'b0;
    end else begin
      gain_scale_q <= scale_d;
      decim_128x_q <= cfg_q.rate_128x;
      mute_q       <= mute_pat_q | (run_q >= RW'(8));
      out_enable_q <= (state_d == PDMC_RUN) & ~clk_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port, answer in the next cycle
  wire [7:0] stat_w = {2'b00, mute_q, out_enable_q, cfg_q.rate_128x,
                       cfg_q.gain, state_q == PDMC_STANDBY};
  wire [7:0] rd_d   = (reg_addr == `PDMC_REG_CTRL) ? ctrl_q :
                      (reg_addr == `PDMC_REG_STAT) ? stat_w : 8'h00;

  always_ff @(posedge clk) begin
    if (core_rst || !reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (core_rst);

  sequence stop_seen_s;
    got_pat && is_stop && spd_en && state_q == PDMC_RUN;
  endsequence

  sequence clk_gone_s;
    clk_lost && state_q != PDMC_POWERDOWN;
  endsequence

  supply_reset_a: assert property (disable iff (rst)
    (!s2_q[0] || !s2_q[1]) |=> !out_enable_q && state_q == PDMC_RUN)
    else $error("bad supply did not reset the core");
  stop_standby_a: assert property (stop_seen_s |=>
    state_q == PDMC_STANDBY ##1 !out_enable_q)
    else $error("stop pattern did not enter standby");
  loss_pd_a: assert property (clk_gone_s |=>
    state_q == PDMC_POWERDOWN && cfg_q == cfg_def)
    else $error("clock loss did not power down with defaults");
  wake_run_a: assert property (state_q == PDMC_POWERDOWN && break_in
    |=> state_q == PDMC_RUN ##1 out_enable_q)
    else $error("non-stop input did not wake the core");
  repeat_cnt_a: assert property (got_pat |->
    run_q == RW'(RUN_BITS - 1) && periodic)
    else $error("pattern acted before full repeat count");
  gain_pat_a: assert property (act && win_d == `PDMC_PAT_G25
    |=> cfg_q.gain == PDMC_GAIN_25 ##1 gain_scale_q == `PDMC_SCALE_G25)
    else $error("gain pattern not applied");
  rate_pat_a: assert property (act && win_d == `PDMC_PAT_RATE
    |=> cfg_q.rate_128x != cfg_def.rate_128x ##1
        decim_128x_q == cfg_q.rate_128x)
    else $error("rate pattern not applied to filter");
  chan_edge_a: assert property (take_bit |->
    (right_s ? fall : rise) ##1 audio_valid_q && audio_bit_q == $past(data_s))
    else $error("wrong channel edge captured");
  strap_dec_a: assert property ($rose(strap_done_q) |->
    cfg_q.rate_128x == strap_q.level_high &&
    cfg_q.gain == (strap_q.via_resistor ? PDMC_GAIN_50 : PDMC_GAIN_36))
    else $error("strap decode wrong");
  mute_pat_a: assert property (take_bit && periodic && run_q >= RW'(8)
    |=> ##1 mute_q)
    else $error("no mute while pattern seen");

  // reset pattern brings back the strap defaults and clears the mute
  rst_pat_a: assert property (act && win_d == `PDMC_PAT_RESET
    |=> cfg_q == cfg_def && !mute_pat_q)
    else $error("reset pattern did not restore defaults");

  // mute pattern keeps the output muted after it has acted
  mute_cmd_a: assert property (act && win_d == `PDMC_PAT_MUTE
    |=> mute_pat_q ##1 mute_q)
    else $error("mute pattern did not mute the output");

endmodule

// File: inc/pdmc_defines.svh
/*
  constants for the pdm input power and config control block.
  assumes inclusion by bare name from the package and the design.
*/
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH

// system clock and pin-clock loss detection
`define PDMC_CLK_HZ       20_000_000
`define PDMC_LOSS_NS      2000
`define PDMC_LOSS_CYC     ((`PDMC_LOSS_NS * (`PDMC_CLK_HZ / 1_000_000)) / 1000)

// control patterns
`define PDMC_PAT_STOP     8'hAC
`define PDMC_PAT_G36      8'hD2
`define PDMC_PAT_G25      8'hD4
`define PDMC_PAT_G50      8'hD8
`define PDMC_PAT_RATE     8'hE4
`define PDMC_PAT_RESET    8'hAA
`define PDMC_PAT_MUTE     8'h66
`define PDMC_PAT_REPEAT   129

// peak output at -6.02 dBFS, tenths of a volt
`define PDMC_SCALE_G50    8'h32
`define PDMC_SCALE_G36    8'h24
`define PDMC_SCALE_G25    8'h19

// register port offsets, fields and reset values
`define PDMC_REG_CTRL     2'h0
`define PDMC_REG_STAT     2'h1
`define PDMC_CTRL_SPD     0
`define PDMC_CTRL_RST     8'h01

`endif

// File: inc/pdmc_pkg.sv
/*
  types for the pdm input power and config control block.
  assumes the defines header is on the include path.
*/
package pdmc_pkg;
  `include "pdmc_defines.svh"

  typedef enum logic [1:0] {
    PDMC_RUN       = 2'b00,
    PDMC_STANDBY   = 2'b01,
    PDMC_POWERDOWN = 2'b10
  } pdmc_state_t;

  typedef enum logic [1:0] {
    PDMC_GAIN_50 = 2'b00,
    PDMC_GAIN_36 = 2'b01,
    PDMC_GAIN_25 = 2'b10
  } pdmc_gain_t;

  // strap pin as seen by the pad sensing: level and resistor present
  typedef struct packed {
    logic level_high;
    logic via_resistor;
  } pdmc_strap_t;

  typedef struct packed {
    pdmc_gain_t gain;
    logic       rate_128x;
  } pdmc_cfg_t;
endpackage

// File: tb/pdmc_src.sv
/*
  pdm source model: bit clock and data, left bit around the rising
  edge, right bit around the falling edge.
  assumes the caller paces bits; the clock stands still between calls.
*/
`timescale 1ns/1ps
module pdmc_src (
  output logic bit_clk,
  output logic bit_dat
);
  initial begin
    bit_clk = 1'b0;
    bit_dat = 1'b0;
  end
  //////////////////////////////////////////////////
  // one 400 ns bit period, data 100 ns each side of the edge
  task automatic send_bit(input logic l, input logic r);
    bit_dat = l;
    #100 bit_clk = 1'b1;
    #100 bit_dat = r;
    #100 bit_clk = 1'b0;
    #100 bit_dat = ~r;   // released line shows the inverse
  endtask
  // one byte per channel, msb first
  task automatic send_byte(input logic [7:0] l, input logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      send_bit(l[i], r[i]);
    end
  endtask
endmodule

// File: tb/pdmc_top_tb.sv
/*
  self-checking bench for the pdm front end with a short repeat count.
  assumes the source model drives the bit clock and data pins.
*/
`timescale 1ns/1ps
module pdmc_top_tb;
  import pdmc_pkg::*;
  logic        clk, rst, sel, psg, lsg, wr, rd, abit, aval, oen, mute, dec;
  logic        bclk, bdat;
  logic [1:0]  addr;
  logic [7:0]  wd, rdq, scale, v;
  pdmc_strap_t strap;
  pdmc_cfg_t   cfg;
  pdmc_state_t st;
  int          bad_count, compares;
  logic [31:0] seed;
  logic [7:0]  pat [6] = '{8'hD2, 8'hD4, 8'hD8, 8'hE4, 8'h66, 8'hAA};
  pdmc_gain_t  pg [6] = '{PDMC_GAIN_36, PDMC_GAIN_25, PDMC_GAIN_50,
                          PDMC_GAIN_50, PDMC_GAIN_50, PDMC_GAIN_50};

  pdmc_top #(.REPEAT(3), .LOSS_CYC(20)) i_dut (
    .clk(clk), .rst(rst), .pdm_clk_in(bclk), .pdm_bitstream_in(bdat),
    .channel_side_select(sel), .gain_rate_strap(strap),
    .power_stage_supply_good(psg), .logic_supply_good(lsg),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_q(rdq), .audio_bit_q(abit), .audio_valid_q(aval),
    .out_enable_q(oen), .mute_q(mute), .cfg_q(cfg), .decim_128x_q(dec),
    .gain_scale_q(scale), .state_q(st));
  pdmc_src i_src (.bit_clk(bclk), .bit_dat(bdat));

  //////////////////////////////////////////////////
  // expectations and helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic pdmc_cfg_t dflt(pdmc_strap_t s);
    dflt.rate_128x = s.level_high;
    dflt.gain = s.via_resistor ? PDMC_GAIN_50 : PDMC_GAIN_36;
  endfunction
  function automatic logic [7:0] scl(pdmc_gain_t g);
    if (g == PDMC_GAIN_50) return `PDMC_SCALE_G50;
    if (g == PDMC_GAIN_36) return `PDMC_SCALE_G36;
    return `PDMC_SCALE_G25;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdq;
  endtask
  // repeated left bytes, random right bytes
  task automatic sendb(input logic [7:0] b, input int n);
    repeat (n) i_src.send_byte(b, rnd());
  endtask
  task automatic wait_st(input pdmc_state_t s);
    for (int i = 0; i < 200; i++) begin
      if (st === s) return;
      @(posedge clk);
      #1;
    end
    chk("state wait", st, s);
    finish_test();
  endtask
  task automatic chk_dflt();
    pdmc_cfg_t c;
    c = dflt(strap);
    chk("cfg", cfg, c);
    chk("scale", scale, scl(c.gain));
    chk("decim", dec, c.rate_128x);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////
  // main sequence
  initial begin
    {seed, bad_count, compares} = {32'd45, 64'd0};
    {rst, sel, psg, lsg, wr, rd, addr, wd} = {6'b101100, 10'h000};
    strap = 2'b11;
    repeat (8) @(posedge clk);
    #1 chk("mute rst", mute, 1);
    chk("scale rst", scale, 8'h24);
    @(posedge clk) rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_dflt();
    chk("oen", oen, 1);
    rd_reg(`PDMC_REG_CTRL, v);
    chk("ctrl", v, `PDMC_CTRL_RST);
    wr_reg(`PDMC_REG_CTRL, 8'h5A);
    rd_reg(`PDMC_REG_CTRL, v);
    chk("ctrl wr", v, 8'h5A);
    wr_reg(2'h2, 8'hFF);
    rd_reg(2'h2, v);
    chk("unmapped", v, 8'h00);
    rd_reg(`PDMC_REG_STAT, v);
    chk("status", v & 8'h1F, 8'h18);
    // channel pick, random bits on both sides
    repeat (16) begin
      @(posedge clk) sel <= seed[3];
      #1 v = rnd();
      i_src.send_bit(v[0], v[1]);
      #250 chk("audio", abit, sel ? v[1] : v[0]);
    end
    @(posedge clk) sel <= 1'b0;
    // stop byte with smart power-down disabled stays running
    sendb(8'h01, 1);
    sendb(`PDMC_PAT_STOP, 5);
    chk("state off", st, PDMC_RUN);
    // each control pattern, runs split by a break byte
    for (int k = 0; k < 6; k++) begin
      sendb(8'h01, 1);
      sendb(pat[k], 2);
      chk("mute pat", mute, 1);
      sendb(pat[k], 3);
      chk("gain", cfg.gain, pg[k]);
      chk("rate", cfg.rate_128x, k != 3 && k != 4);
      chk("scale", scale, scl(pg[k]));
      chk("decim", dec, k != 3 && k != 4);
    end
    #2000 wait_st(PDMC_POWERDOWN);
    chk_dflt();
    for (int k = 0; k < 2; k++) begin
      sendb(8'h00, 1);
      sendb(8'hFF, 1);
      wait_st(PDMC_RUN);
      chk_dflt();
      chk("oen wake", oen, 1);
      wr_reg(`PDMC_REG_CTRL, 8'h01);
      sendb(8'h01, 1);
      sendb(`PDMC_PAT_STOP, 5);
      chk("state sb", st, PDMC_STANDBY);
      chk("oen sb", oen, 0);
      #2000 wait_st(PDMC_POWERDOWN);
    end
    // supply loss, then relatch a new strap
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      strap <= k ? 2'b10 : 2'b00;
      psg <= k[0];
      lsg <= ~k[0];
      repeat (4) @(posedge clk);
      #1 chk("oen sup", oen, 0);
      chk("mute sup", mute, 1);
      @(posedge clk) {psg, lsg} <= 2'b11;
      repeat (6) @(posedge clk);
      #1 chk_dflt();
    end
    finish_test();
  end
endmodule
